// file: hdl/hpsel_pkg.sv
package hpsel_pkg;

	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int unsigned CLK_FREQ_HZ        = 20000000;
	localparam int unsigned CLK_PER_NS         = 50;
	// settle pause after a priority change, least value, microseconds
	localparam int unsigned SETTLE_PAUSE_US    = 2000;
	// unplug switch interval, least value, milliseconds
	localparam int unsigned SWITCH_INTERVAL_MS = 170;
	// shortest low pulse that must be repeated, nanoseconds
	localparam int unsigned MIN_PULSE_NS       = 100;
	// longest allowed repeat delay, nanoseconds
	localparam int unsigned REPEAT_DELAY_NS    = 110;

	localparam int unsigned TMR_W = 22;
	localparam int unsigned SETTLE_CYC_INT =
		(SETTLE_PAUSE_US * (CLK_FREQ_HZ / 1000000));
	localparam int unsigned SWITCH_CYC_INT =
		(SWITCH_INTERVAL_MS * (CLK_FREQ_HZ / 1000));
	localparam logic [TMR_W-1:0] SETTLE_CYC = TMR_W'(SETTLE_CYC_INT);
	localparam logic [TMR_W-1:0] SWITCH_CYC = TMR_W'(SWITCH_CYC_INT);
	// repeat delay limit in whole clock cycles (two); one register stage fits in it
	localparam int unsigned REPEAT_DELAY_CYC = REPEAT_DELAY_NS / CLK_PER_NS;

	// ****************************************************************
	// states
	// ****************************************************************
	typedef enum logic [3:0]
	{
		ST_IDLE   = 4'h1,
		ST_ACTIVE = 4'h2,
		ST_SETTLE = 4'h4,
		ST_FORCE  = 4'h8
	} hpsel_state_e;

endpackage

// file: hdl/hpsel_port_select.sv
`timescale 1ns/1ns
// Notes on behaviour
// (R1) both plug inputs low: low power, outputs high impedance, link shut down
// (R2) one plug input rises: select that port, enable and repeat its level
// (R3) both plug inputs high: priority input decides the selected port
// (R4) low power allowed low at plug: stay low power but select and repeat
// (R5) low power allowed high at plug: enable main link and auxiliary paths
// (R6) low pulses on selected input repeat on output with same width
// (R7) sink keeps interrupt pulses at least the minimum repeatable width
// (R8) sole port low longer than switch interval: unplug, enter low power
// (R9) that port high again: wake exactly as on a first plug
// (R10) both high, selected low longer than switch interval: select other port
// (R11) priority port high and selected: ignore the other port entirely
// (R12) priority port rises while other selected: force output low one interval
// (R13) priority input low during forced interval restarts the interval
// (R14) forced interval over: select priority port, repeat its level again
// (R15) a low port is never selected; priority change alone then does nothing
// (R16) both high and priority input changes: move selection to other port
// (R17) priority change waits the settle pause first, filtering glitches
// (R18) after settle pause: forced low interval, then switch as on arrival
// (R19) settle pause lies between 2 and 4.7 ms
// (R20) switch interval lies between 170 and 400 ms
// (R21) low pulses of 100 ns or more are repeated
// (R22) priority input high favours port a, low favours port b
// (R23) timers count the system clock, limits are parameters
module hpsel_port_select
#(
	parameter logic [hpsel_pkg::TMR_W-1:0] SETTLE_CYC = hpsel_pkg::SETTLE_CYC,
	parameter logic [hpsel_pkg::TMR_W-1:0] SWITCH_CYC = hpsel_pkg::SWITCH_CYC
)
(
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic clk_en,
	input  wire logic plug_detect_in_port_a,
	input  wire logic plug_detect_in_port_b,
	input  wire logic priority_port_a,
	input  wire logic low_power_allow_n,
	output logic      sel_port_b_q,
	output logic      sel_valid_q,
	output logic      plug_detect_out_q,
	output logic      plug_detect_out_oe_q,
	output logic      link_enable_q,
	output logic      low_power_q
);
	import hpsel_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	hpsel_state_e           st_q;
	hpsel_state_e           st_d;
	logic [TMR_W-1:0]       tmr_q;
	logic [TMR_W-1:0]       tmr_d;
	logic                   sel_d;
	logic                   link_d;
	logic                   out_d;
	logic                   a_prev_q;
	logic                   b_prev_q;
	logic                   prio_prev_q;
	logic                   sel_in;
	logic                   oth_in;
	logic                   pri_b;
	logic                   pri_in;
	logic                   pri_rise;
	logic                   both_high;
	logic                   prio_chg;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		sel_in    = sel_port_b_q ? plug_detect_in_port_b : plug_detect_in_port_a;
		oth_in    = sel_port_b_q ? plug_detect_in_port_a : plug_detect_in_port_b;
		pri_b     = ~priority_port_a;                                      // [R22]
		pri_in    = pri_b ? plug_detect_in_port_b : plug_detect_in_port_a;
		pri_rise  = pri_b ? (plug_detect_in_port_b & ~b_prev_q)
		                  : (plug_detect_in_port_a & ~a_prev_q);
		both_high = plug_detect_in_port_a & plug_detect_in_port_b;
		prio_chg  = priority_port_a ^ prio_prev_q;
		st_d      = st_q;
		tmr_d     = tmr_q;
		sel_d     = sel_port_b_q;
		link_d    = link_enable_q;
		case (st_q)
			ST_IDLE:
			begin
				// asleep, pins released
				tmr_d  = '0;
				link_d = 1'b0;                                             // [R1]
				if (plug_detect_in_port_a | plug_detect_in_port_b)
				begin
					st_d   = ST_ACTIVE;                                    // [R2] [R9]
					// only a high port can win
					sel_d  = both_high ? pri_b : plug_detect_in_port_b;    // [R3] [R15]
					link_d = low_power_allow_n;                            // [R4] [R5]
				end
			end
			ST_ACTIVE:
			begin
				// the timer measures how long the selected input stays low
				tmr_d = sel_in ? '0 : TMR_W'(tmr_q + 1'b1);                // [R23]
				if (!sel_in && (tmr_q == SWITCH_CYC - 1'b1))
				begin
					tmr_d = '0;
					if (oth_in)
						sel_d = ~sel_port_b_q;                             // [R10]
					else
					begin
						st_d   = ST_IDLE;                                  // [R8]
						link_d = 1'b0;
					end
				end
				else if (sel_in && both_high && prio_chg)
				begin
					st_d  = ST_SETTLE;                                     // [R16] [R17]
					tmr_d = '0;
				end
				else if (sel_in && (sel_port_b_q != pri_b) && pri_rise)
				begin
					st_d  = ST_FORCE;                                      // [R12]
					tmr_d = '0;
				end
				// priority port selected and high: the other port cannot move it, only a priority change can [R11]
			end
			ST_SETTLE:
			begin
				tmr_d = TMR_W'(tmr_q + 1'b1);
				if (!both_high)
				begin
					// one port left: priority no longer matters
					st_d  = ST_ACTIVE;                                     // [R15]
					tmr_d = '0;
				end
				else if (prio_chg)
					tmr_d = '0;                                            // [R17]
				else if (tmr_q == SETTLE_CYC - 1'b1)
				begin
					tmr_d = '0;
					st_d  = (sel_port_b_q != pri_b) ? ST_FORCE : ST_ACTIVE; // [R18] [R19]
				end
			end
			ST_FORCE:
			begin
				if (!pri_in)
					tmr_d = '0;                                            // [R13]
				else if (tmr_q == SWITCH_CYC - 1'b1)
				begin
					st_d  = ST_ACTIVE;                                     // [R14]
					sel_d = pri_b;
					tmr_d = '0;
				end
				else
					tmr_d = TMR_W'(tmr_q + 1'b1);                          // [R20]
			end
			default:
			begin
				st_d   = ST_IDLE;
				tmr_d  = '0;
				link_d = 1'b0;
			end
		endcase
		// one flop of delay keeps the repeat within its window and pulse widths equal
		out_d = ((st_d == ST_ACTIVE) || (st_d == ST_SETTLE))
		        & (sel_d ? plug_detect_in_port_b : plug_detect_in_port_a); // [R6] [R21]
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q                 <= ST_IDLE;
			tmr_q                <= '0;
			sel_port_b_q         <= 1'b0;
			sel_valid_q          <= 1'b0;
			plug_detect_out_q    <= 1'b0;
			plug_detect_out_oe_q <= 1'b0;
			link_enable_q        <= 1'b0;
			low_power_q          <= 1'b1;
			a_prev_q             <= 1'b0;
			b_prev_q             <= 1'b0;
			prio_prev_q          <= 1'b0;
		end
		else if (clk_en)
		begin
			st_q                 <= st_d;
			tmr_q                <= tmr_d;
			sel_port_b_q         <= sel_d;
			sel_valid_q          <= (st_d != ST_IDLE);
			plug_detect_out_q    <= out_d;
			plug_detect_out_oe_q <= (st_d != ST_IDLE);                     // [R1]
			link_enable_q        <= link_d;
			low_power_q          <= ~link_d;
			a_prev_q             <= plug_detect_in_port_a;
			b_prev_q             <= plug_detect_in_port_b;
			prio_prev_q          <= priority_port_a;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence s_wake;
		clk_en && (st_q == ST_IDLE) && (st_d == ST_ACTIVE);
	endsequence

	sequence s_force_done;
		clk_en && (st_q == ST_FORCE) && (st_d == ST_ACTIVE);
	endsequence

	a_idle_hiz: assert property (                                          // [R1]
		(st_q == ST_IDLE) |-> (!plug_detect_out_oe_q && !link_enable_q && low_power_q))
		else $error("idle state does not release outputs");

	a_wake_select: assert property (                                       // [R2]
		s_wake |=> sel_valid_q && plug_detect_out_oe_q
		&& (sel_port_b_q ? $past(plug_detect_in_port_b) : $past(plug_detect_in_port_a)))
		else $error("wake selected a port whose input was low");

	a_wake_prio: assert property (                                         // [R3]
		(s_wake and (plug_detect_in_port_a && plug_detect_in_port_b))
		|=> (sel_port_b_q == !$past(priority_port_a)))
		else $error("both high at wake but priority ignored");

	a_wake_link: assert property (                                         // [R4]
		s_wake |=> (link_enable_q == $past(low_power_allow_n)))
		else $error("link enable does not match low power allow at wake");

	a_repeat_lvl: assert property (                                        // [R6]
		(clk_en && (st_q == ST_ACTIVE) && (st_d == ST_ACTIVE))
		|=> (plug_detect_out_q == (sel_port_b_q ? $past(plug_detect_in_port_b)
		                                        : $past(plug_detect_in_port_a))))
		else $error("output does not repeat the selected input");

	a_unplug_idle: assert property (                                       // [R8]
		(clk_en && (st_q == ST_ACTIVE) && (st_d == ST_IDLE))
		|-> (tmr_q == SWITCH_CYC - 1'b1) && !sel_in && !oth_in)
		else $error("unplug taken before the switch interval");

	a_unplug_swap: assert property (                                       // [R10]
		(clk_en && (st_q == ST_ACTIVE) && !sel_in && oth_in
		&& (tmr_q == SWITCH_CYC - 1'b1))
		|=> (sel_port_b_q != $past(sel_port_b_q)) && (st_q == ST_ACTIVE))
		else $error("selection did not move after long low");

	a_pri_hold: assert property (                                          // [R11]
		(clk_en && (st_q == ST_ACTIVE) && (sel_port_b_q == pri_b) && sel_in
		&& !(both_high && prio_chg))
		|=> $stable(sel_port_b_q) && (st_q == ST_ACTIVE))
		else $error("priority port lost selection");

	a_force_low: assert property (                                         // [R12]
		(st_q == ST_FORCE) |-> (!plug_detect_out_q && plug_detect_out_oe_q))
		else $error("output not held low during forced interval");

	a_force_rst: assert property (                                         // [R13]
		(clk_en && (st_q == ST_FORCE) && !pri_in) |=> (tmr_q == '0))
		else $error("forced interval not restarted");

	a_force_exit: assert property (                                        // [R14]
		s_force_done |-> (tmr_q == SWITCH_CYC - 1'b1)
		##1 (sel_port_b_q == $past(pri_b)))
		else $error("forced interval ended early or wrong port");

	a_settle_exit: assert property (                                       // [R17]
		(clk_en && (st_q == ST_SETTLE) && (st_d == ST_FORCE))
		|-> (tmr_q == SETTLE_CYC - 1'b1) && !prio_chg && both_high)
		else $error("settle pause ended early");

endmodule

// file: verification/hpsel_sink_model.sv
`timescale 1ns/1ns
// ****************************************************************
// two sink ports driving plug detect levels
// ****************************************************************
module hpsel_sink_model
#(
	parameter int MIN_LOW = hpsel_pkg::MIN_PULSE_NS / hpsel_pkg::CLK_PER_NS
)
(
	input  wire logic clk_sys,
	input  wire logic want_a,
	input  wire logic want_b,
	output logic      plug_a,
	output logic      plug_b
);
	int low_a = 0;
	int low_b = 0;
	initial plug_a = 1'h0;
	initial plug_b = 1'h0;
	// a low pulse is stretched to the repeatable width, never cut short
	always @(posedge clk_sys)
	begin
		low_a = plug_a ? 0 : low_a + 1;
		low_b = plug_b ? 0 : low_b + 1;
		plug_a <= (!plug_a && low_a < MIN_LOW) ? 1'h0 : want_a;
		plug_b <= (!plug_b && low_b < MIN_LOW) ? 1'h0 : want_b;
	end
endmodule

// file: verification/tb_hot_plug_port_select_logic.sv
`timescale 1ns/1ns
module tb_hot_plug_port_select_logic;
	import hpsel_pkg::*;
	// short timers keep the run small; expectations derive from these
	localparam int NS = 20;
	localparam int NW = 50;
	localparam int LIMIT = 4000;
	logic clk_sys, nrst, clk_en, want_a, want_b, prio, lpn, mon_on;
	logic pa, pb, sel_b, valid, out, oe, link, lowp;
	int   bad_count = 0;
	int   checks_done = 0;
	int   cyc = 0;
	int   m_sel, m_valid, m_link, w;
	logic q[$];

	hpsel_port_select #(.SETTLE_CYC(TMR_W'(NS)), .SWITCH_CYC(TMR_W'(NW))) i_hpsel_port_select (
		.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
		.plug_detect_in_port_a(pa), .plug_detect_in_port_b(pb),
		.priority_port_a(prio), .low_power_allow_n(lpn),
		.sel_port_b_q(sel_b), .sel_valid_q(valid), .plug_detect_out_q(out),
		.plug_detect_out_oe_q(oe), .link_enable_q(link), .low_power_q(lowp));
	hpsel_sink_model i_hpsel_sink_model (.clk_sys(clk_sys), .want_a(want_a),
		.want_b(want_b), .plug_a(pa), .plug_b(pb));

	initial
	begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// compare design with model at a settled point; eo < 0 skips the output
	task automatic chk(input int eo);
		@(negedge clk_sys);
		check({valid, oe, link, lowp}, {m_valid[0], m_valid[0], m_link[0], !m_link[0]});
		if (m_valid != 0)
			check(sel_b, m_sel[0]);
		if (eo >= 0)
			check(out, eo[0]);
		@(posedge clk_sys);
	endtask

	// output repeats the selected input one cycle later
	always @(negedge clk_sys)
	begin
		if (!mon_on)
			q.delete();
		else
		begin
			if (q.size() > 0)
				check(out, q.pop_front());
			q.push_back(m_sel != 0 ? pb : pa);
		end
	end

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			bad_count++;
			print_verdict();
		end
	end

	initial
	begin
		{nrst, want_a, want_b, lpn, mon_on} = 5'h00;
		clk_en = 1'h1;
		prio = 1'h1;
		m_sel = 0;
		m_valid = 0;
		m_link = 0;
		void'($urandom(93719));
		step(5);
		nrst <= 1'h1;
		step(2);
		chk(0);
		want_a <= 1'h1;
		step(3);
		m_valid = 1;
		chk(1);
		mon_on = 1'h1;
		// random low pulses, the first at the shortest repeatable width
		for (int i = 0; i < 5; i++)
		begin
			w = (i == 0) ? 2 : 2 + $urandom % 30;
			want_a <= 1'h0;
			step(w);
			want_a <= 1'h1;
			step(3 + $urandom % 6);
		end
		mon_on = 1'h0;
		want_a <= 1'h0;
		step(NW + 4);
		m_valid = 0;
		chk(-1);
		lpn <= 1'h1;
		step(1);
		want_a <= 1'h1;
		step(3);
		m_valid = 1;
		m_link = 1;
		chk(1);
		prio <= 1'h0;
		step(NS + NW + 10);
		chk(1);
		prio <= 1'h1;
		step(NS + 4);
		want_b <= 1'h1;
		step(NW);
		want_b <= 1'h0;
		step(4);
		want_b <= 1'h1;
		step(NW + NS);
		chk(1);
		prio <= 1'h0;
		step(NS - 3);
		chk(1);
		step(6);
		chk(0);
		step(NW - 10);
		chk(0);
		want_b <= 1'h0;
		step(2);
		want_b <= 1'h1;
		step(NW - 4);
		chk(0);
		step(10);
		m_sel = 1;
		chk(1);
		want_b <= 1'h0;
		step(NW + 4);
		m_sel = 0;
		chk(1);
		want_b <= 1'h1;
		step(3);
		chk(0);
		step(NW + 5);
		m_sel = 1;
		chk(1);
		{want_a, want_b} <= 2'h0;
		step(NW + 4);
		m_valid = 0;
		m_link = 0;
		chk(-1);
		prio <= 1'($urandom % 2);
		step(3);
		{want_a, want_b} <= 2'h3;
		step(3);
		m_valid = 1;
		m_link = 1;
		m_sel = !prio;
		chk(1);
		// clock enable low: both ports drop but every flop must hold
		clk_en <= 1'h0;
		{want_a, want_b} <= 2'h0;
		step(NW + 4);
		chk(1);
		clk_en <= 1'h1;
		step(NW + 4);
		m_valid = 0;
		m_link = 0;
		chk(-1);
		print_verdict();
	end
endmodule
